/* rtl/mie_regs.svh */
// Constants for the instruction execute block
`ifndef MIE_REGS_SVH
`define MIE_REGS_SVH
`define MIE_DATA_W        8
`define MIE_PC_W          15
`define MIE_PTR_W         16
`define MIE_FADDR_W       7
`define MIE_OSC_PER_CYC   4
`define MIE_ZERO_BYTE     8'h00
`define MIE_PC_LIT_HI     10
`define MIE_LATCH_HI      6
`define MIE_LATCH_LO_CALL 3
`define MIE_DC_BIT        3
`endif

/* rtl/mie_pkg.sv */
// Types shared by the instruction execute block
package mie_pkg;
	typedef enum logic [4:0] {
		MIE_OP_NO_OPERATION             = 5'h00,
		MIE_OP_ADD_LITERAL_TO_POINTER   = 5'h01,
		MIE_OP_ADD_LITERAL              = 5'h02,
		MIE_OP_AND_LITERAL              = 5'h03,
		MIE_OP_OR_LITERAL               = 5'h04,
		MIE_OP_AND_REGISTER             = 5'h05,
		MIE_OP_ADD_REGISTER             = 5'h06,
		MIE_OP_ADD_REGISTER_WITH_CARRY  = 5'h07,
		MIE_OP_ARITH_SHIFT_RIGHT        = 5'h08,
		MIE_OP_BIT_CLEAR                = 5'h09,
		MIE_OP_BIT_SET                  = 5'h0A,
		MIE_OP_BIT_TEST_SKIP_CLEAR      = 5'h0B,
		MIE_OP_BIT_TEST_SKIP_SET        = 5'h0C,
		MIE_OP_RELATIVE_BRANCH          = 5'h0D,
		MIE_OP_BRANCH_BY_ACCUMULATOR    = 5'h0E,
		MIE_OP_CALL                     = 5'h0F,
		MIE_OP_CALL_BY_ACCUMULATOR      = 5'h10,
		MIE_OP_WATCHDOG_CLEAR           = 5'h11,
		MIE_OP_CLEAR_REGISTER           = 5'h12,
		MIE_OP_CLEAR_ACCUMULATOR        = 5'h13,
		MIE_OP_COMPLEMENT_REGISTER      = 5'h14,
		MIE_OP_DECREMENT_REGISTER       = 5'h15,
		MIE_OP_DECREMENT_SKIP_ZERO      = 5'h16,
		MIE_OP_INCREMENT_SKIP_ZERO      = 5'h17,
		MIE_OP_ABSOLUTE_BRANCH          = 5'h18
	} mie_op_type;

	typedef enum logic [1:0] {
		MIE_ST_EXEC  = 2'b00,
		MIE_ST_FLUSH = 2'b01,
		MIE_ST_EXTRA = 2'b10
	} mie_state_type;

	// One decoded instruction from the fetch stage
	typedef struct packed {
		mie_op_type  op;
		logic        dest_file;
		logic [6:0]  file_addr;
		logic [2:0]  bit_sel;
		logic        ptr_sel;
		logic [10:0] literal;
		logic        indirect;
	} mie_instr_type;

	// Status flags
	typedef struct packed {
		logic timeout_flag;
		logic powerdown_flag;
		logic zero_flag;
		logic digit_carry_flag;
		logic carry_flag;
	} mie_status_type;
endpackage : mie_pkg

/* rtl/mie_execute.sv */
// Instruction execute stage of an 8-bit microcontroller core
`timescale 1ns/10ps
`default_nettype none
`include "mie_regs.svh"
module mie_execute
	import mie_pkg::*;
#(
	parameter int DATA_W = `MIE_DATA_W,
	parameter int PC_W   = `MIE_PC_W,
	parameter int PTR_W  = `MIE_PTR_W
) (
	// Clock and reset
	input  wire logic                     core_clk,
	input  wire logic                     reset_n,
	// Decoded instruction from fetch
	input  wire logic                     instr_valid,
	input  wire mie_instr_type            instr,
	output logic                          instr_ready,
	// File register read, same clock, combinational data
	output logic [`MIE_FADDR_W-1:0]       file_rd_addr,
	input  wire logic [DATA_W-1:0]        file_rd_data,
	// File register write
	output logic                          file_wr_en,
	output logic [`MIE_FADDR_W-1:0]       file_wr_addr,
	output logic [DATA_W-1:0]             file_wr_data,
	// Indirect pointers, owned here
	output logic [PTR_W-1:0]              indirect_pointer_pair [2],
	// Program counter and stack push
	input  wire logic [PC_W-1:0]          pc_current,
	input  wire logic [DATA_W-2:0]        pc_high_latch,
	output logic                          pc_load,
	output logic [PC_W-1:0]               pc_target,
	output logic                          stack_push,
	output logic [PC_W-1:0]               stack_top,
	// Watchdog
	output logic                          watchdog_clear,
	// Working register and flags
	output logic [DATA_W-1:0]             accumulator,
	output mie_status_type                status,
	// Phase of the instruction cycle
	output logic [1:0]                    osc_phase,
	output logic                          cycle_strobe
);

	// Encoding fixes the data and counter widths
	if (DATA_W != 8) begin : g_bad_data_w
		$error("mie_execute: DATA_W must be 8");
	end
	if (PC_W != 15) begin : g_bad_pc_w
		$error("mie_execute: PC_W must be 15");
	end
	// Offset sign extension needs more than six pointer bits
	if (PTR_W < 7) begin : g_bad_ptr_w
		$error("mie_execute: PTR_W must exceed 6");
	end

	function automatic logic is_zero(input logic [DATA_W-1:0] v);
		return v == `MIE_ZERO_BYTE;
	endfunction : is_zero

	// One-hot mask for the bit field of bit operations
	function automatic logic [DATA_W-1:0] bit_mask(input logic [2:0] sel);
		logic [DATA_W-1:0] m;
		m      = '0;
		m[sel] = 1'b1;
		return m;
	endfunction : bit_mask

	// Byte operations whose result follows the destination bit
	function automatic logic is_routed_op(input mie_op_type op);
		case (op)
			MIE_OP_AND_REGISTER, MIE_OP_COMPLEMENT_REGISTER,
			MIE_OP_DECREMENT_REGISTER, MIE_OP_ADD_REGISTER,
			MIE_OP_ADD_REGISTER_WITH_CARRY, MIE_OP_ARITH_SHIFT_RIGHT,
			MIE_OP_DECREMENT_SKIP_ZERO, MIE_OP_INCREMENT_SKIP_ZERO: begin
				return 1'b1;
			end
			default: begin
				return 1'b0;
			end
		endcase
	endfunction : is_routed_op

	// Oscillator phase counter; one instruction per four phases
	logic [1:0] next_osc_phase;
	always_comb begin
		next_osc_phase = osc_phase + 2'h1;
	end
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			osc_phase <= 2'h0;
		end else begin
			osc_phase <= next_osc_phase;
		end
	end
	localparam logic [1:0] LAST_PHASE = 2'(`MIE_OSC_PER_CYC - 1);
	assign cycle_strobe = (osc_phase == LAST_PHASE);

	// Execution state
	mie_state_type  state;
	mie_state_type  next_state;
	logic [DATA_W-1:0] next_accumulator;
	mie_status_type    next_status;
	logic [PTR_W-1:0]  next_ptr [2];
	logic              next_wr_en;
	logic [`MIE_FADDR_W-1:0] next_wr_addr;
	logic [DATA_W-1:0] next_wr_data;
	logic              next_pc_load;
	logic [PC_W-1:0]   next_pc_target;
	logic              next_push;
	logic [PC_W-1:0]   next_stack_top;
	logic              next_wdt_clr;
	logic              extra_pending;
	logic              next_extra_pending;

	logic [DATA_W:0]   sum;
	logic [4:0]        low_sum;
	logic [DATA_W-1:0] addend;
	logic              carry_in;
	logic [DATA_W-1:0] result;
	logic [PC_W-1:0]   pc_inc;
	logic              take;

	assign file_rd_addr = instr.file_addr;
	assign instr_ready  = cycle_strobe && (state == MIE_ST_EXEC);
	assign take         = instr_ready && instr_valid;
	assign pc_inc       = pc_current + 15'h0001;

	always_comb begin
		next_state         = state;
		next_accumulator   = accumulator;
		next_status        = status;
		next_ptr           = indirect_pointer_pair;
		next_wr_en         = 1'b0;
		next_wr_data       = file_wr_data;
		next_wr_addr       = take ? instr.file_addr : file_wr_addr;
		next_pc_load       = 1'b0;
		next_pc_target     = pc_target;
		next_push          = 1'b0;
		next_stack_top     = stack_top;
		next_wdt_clr       = 1'b0;
		next_extra_pending = extra_pending;
		addend             = file_rd_data;
		carry_in           = 1'b0;
		result             = file_rd_data;
		sum                = '0;
		low_sum            = '0;
		if (cycle_strobe) begin
			case (state)
				MIE_ST_EXEC: begin
					if (instr_valid) begin
						// Pointer top bit set means the indirect target is slow
						next_extra_pending = instr.indirect
							&& indirect_pointer_pair[instr.ptr_sel][PTR_W-1];
						if (instr.op == MIE_OP_ADD_LITERAL
							|| instr.op == MIE_OP_AND_LITERAL
							|| instr.op == MIE_OP_OR_LITERAL) begin
							addend = instr.literal[DATA_W-1:0];
						end
						if (instr.op == MIE_OP_ADD_REGISTER_WITH_CARRY) begin
							carry_in = status.carry_flag;
						end
						sum = {1'b0, accumulator} + {1'b0, addend}
							+ {{DATA_W{1'b0}}, carry_in};
						low_sum = {1'b0, accumulator[3:0]} + {1'b0, addend[3:0]}
							+ {4'h0, carry_in};
						case (instr.op)
							MIE_OP_ADD_LITERAL_TO_POINTER: begin
								// Sign extend and wrap modulo pointer range
								next_ptr[instr.ptr_sel] = indirect_pointer_pair[instr.ptr_sel]
									+ PTR_W'({{(PTR_W-6){instr.literal[5]}},
									instr.literal[5:0]});
							end
							MIE_OP_ADD_LITERAL: begin
								next_accumulator = sum[DATA_W-1:0];
								next_status.carry_flag       = sum[DATA_W];
								next_status.digit_carry_flag = low_sum[4];
								next_status.zero_flag        = is_zero(sum[DATA_W-1:0]);
							end
							MIE_OP_AND_LITERAL: begin
								result = accumulator & addend;
								next_accumulator = result;
								next_status.zero_flag = is_zero(result);
							end
							MIE_OP_OR_LITERAL: begin
								result = accumulator | addend;
								next_accumulator = result;
								next_status.zero_flag = is_zero(result);
							end
							MIE_OP_AND_REGISTER, MIE_OP_COMPLEMENT_REGISTER,
							MIE_OP_DECREMENT_REGISTER: begin
								if (instr.op == MIE_OP_AND_REGISTER) begin
									result = accumulator & file_rd_data;
								end else if (instr.op == MIE_OP_COMPLEMENT_REGISTER) begin
									result = ~file_rd_data;
								end else begin
									result = file_rd_data - 8'h01;
								end
								next_status.zero_flag = is_zero(result);
							end
							MIE_OP_ADD_REGISTER, MIE_OP_ADD_REGISTER_WITH_CARRY: begin
								result = sum[DATA_W-1:0];
								next_status.carry_flag       = sum[DATA_W];
								next_status.digit_carry_flag = low_sum[4];
								next_status.zero_flag        = is_zero(result);
							end
							MIE_OP_ARITH_SHIFT_RIGHT: begin
								result = {file_rd_data[7], file_rd_data[7:1]};
								next_status.carry_flag = file_rd_data[0];
								next_status.zero_flag  = is_zero(result);
							end
							MIE_OP_BIT_CLEAR: begin
								result = file_rd_data & ~bit_mask(instr.bit_sel);
							end
							MIE_OP_BIT_SET: begin
								result = file_rd_data | bit_mask(instr.bit_sel);
							end
							MIE_OP_BIT_TEST_SKIP_CLEAR: begin
								if ((file_rd_data & bit_mask(instr.bit_sel)) == '0) begin
									next_state = MIE_ST_FLUSH;
								end
							end
							MIE_OP_BIT_TEST_SKIP_SET: begin
								if ((file_rd_data & bit_mask(instr.bit_sel)) != '0) begin
									next_state = MIE_ST_FLUSH;
								end
							end
							MIE_OP_RELATIVE_BRANCH: begin
								next_pc_load   = 1'b1;
								next_pc_target = pc_inc
									+ PC_W'({{(PC_W-9){instr.literal[8]}}, instr.literal[8:0]});
								next_state     = MIE_ST_FLUSH;
							end
							MIE_OP_BRANCH_BY_ACCUMULATOR: begin
								next_pc_load   = 1'b1;
								next_pc_target = pc_inc + PC_W'(accumulator);
								next_state     = MIE_ST_FLUSH;
							end
							MIE_OP_CALL, MIE_OP_ABSOLUTE_BRANCH: begin
								next_pc_load   = 1'b1;
								next_pc_target = {pc_high_latch[`MIE_LATCH_HI:`MIE_LATCH_LO_CALL],
									instr.literal[`MIE_PC_LIT_HI:0]};
								next_push      = (instr.op == MIE_OP_CALL);
								next_stack_top = next_push ? pc_inc : stack_top;
								next_state     = MIE_ST_FLUSH;
							end
							MIE_OP_CALL_BY_ACCUMULATOR: begin
								next_pc_load   = 1'b1;
								next_pc_target = {pc_high_latch, accumulator};
								next_push      = 1'b1;
								next_stack_top = pc_inc;
								next_state     = MIE_ST_FLUSH;
							end
							MIE_OP_WATCHDOG_CLEAR: begin
								next_wdt_clr = 1'b1;
								next_status.timeout_flag   = 1'b1;
								next_status.powerdown_flag = 1'b1;
							end
							MIE_OP_CLEAR_REGISTER: begin
								result = `MIE_ZERO_BYTE;
								next_status.zero_flag = 1'b1;
							end
							MIE_OP_CLEAR_ACCUMULATOR: begin
								next_accumulator = `MIE_ZERO_BYTE;
								next_status.zero_flag = 1'b1;
							end
							MIE_OP_DECREMENT_SKIP_ZERO, MIE_OP_INCREMENT_SKIP_ZERO: begin
								// No flags change here, unlike plain decrement
								result = (instr.op == MIE_OP_DECREMENT_SKIP_ZERO)
									? file_rd_data - 8'h01 : file_rd_data + 8'h01;
								if (is_zero(result)) begin
									next_state = MIE_ST_FLUSH;
								end
							end
							default: begin
								result = file_rd_data;
							end
						endcase
						// Result routing for byte operations
						if (is_routed_op(instr.op)) begin
							if (instr.dest_file) begin
								next_wr_en   = 1'b1;
								next_wr_data = result;
							end else begin
								next_accumulator = result;
							end
						end else if (instr.op == MIE_OP_BIT_CLEAR || instr.op == MIE_OP_BIT_SET
							|| instr.op == MIE_OP_CLEAR_REGISTER) begin
							next_wr_en   = 1'b1;
							next_wr_data = result;
						end
						if (next_state == MIE_ST_EXEC && next_extra_pending) begin
							next_state         = MIE_ST_EXTRA;
							next_extra_pending = 1'b0;
						end
					end
				end
				MIE_ST_FLUSH: begin
					// Discarded slot runs as a no-operation
					next_state = extra_pending ? MIE_ST_EXTRA : MIE_ST_EXEC;
					next_extra_pending = 1'b0;
				end
				MIE_ST_EXTRA: begin
					next_state = MIE_ST_EXEC;
				end
				default: begin
					next_state = MIE_ST_EXEC;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state                    <= MIE_ST_EXEC;
			accumulator              <= '0;
			status                   <= '{timeout_flag: 1'b1, powerdown_flag: 1'b1,
				default: 1'b0};
			indirect_pointer_pair[0] <= '0;
			indirect_pointer_pair[1] <= '0;
			file_wr_en               <= 1'b0;
			file_wr_addr             <= '0;
			file_wr_data             <= '0;
			pc_load                  <= 1'b0;
			pc_target                <= '0;
			stack_push               <= 1'b0;
			stack_top                <= '0;
			watchdog_clear           <= 1'b0;
			extra_pending            <= 1'b0;
		end else begin
			state                    <= next_state;
			accumulator              <= next_accumulator;
			status                   <= next_status;
			indirect_pointer_pair[0] <= next_ptr[0];
			indirect_pointer_pair[1] <= next_ptr[1];
			file_wr_en               <= next_wr_en;
			file_wr_addr             <= next_wr_addr;
			file_wr_data             <= next_wr_data;
			pc_load                  <= next_pc_load;
			pc_target                <= next_pc_target;
			stack_push               <= next_push;
			stack_top                <= next_stack_top;
			watchdog_clear           <= next_wdt_clr;
			extra_pending            <= next_extra_pending;
		end
	end

endmodule : mie_execute
`default_nettype wire

/* dv/mie_execute_checker.sv */
// Concurrent checks on the ports of the instruction execute block
`timescale 1ns/10ps
`default_nettype none
module mie_execute_checker
	import mie_pkg::*;
(
	// Clock and reset
	input wire logic           core_clk,
	input wire logic           reset_n,
	// Instruction side
	input wire logic           instr_valid,
	input wire mie_instr_type  instr,
	input wire logic           instr_ready,
	input wire logic [7:0]     file_rd_data,
	input wire logic [14:0]    pc_current,
	input wire logic [6:0]     pc_high_latch,
	// Results
	input wire logic           file_wr_en,
	input wire logic [7:0]     file_wr_data,
	input wire logic           pc_load,
	input wire logic [14:0]    pc_target,
	input wire logic           stack_push,
	input wire logic [14:0]    stack_top,
	input wire logic           watchdog_clear,
	input wire logic [7:0]     accumulator,
	input wire mie_status_type status,
	input wire logic [1:0]     osc_phase
);
	logic       tk;
	mie_op_type op;
	assign tk = instr_valid && instr_ready;
	assign op = instr.op;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);

	chk_phase_step: assert property (reset_n |=> osc_phase == $past(osc_phase) + 2'h1)
		else $error("oscillator phase did not advance by one");
	chk_ready_slot: assert property (instr_ready |-> osc_phase == 2'h3)
		else $error("ready outside the last phase");
	chk_add_lit: assert property (tk && op == MIE_OP_ADD_LITERAL |=>
		{status.carry_flag, accumulator} == {1'b0, $past(accumulator)} + {1'b0, $past(instr.literal[7:0])}
		&& status.zero_flag == (accumulator == 8'h00)) else $error("add literal result wrong");
	chk_digit_carry: assert property (tk && op == MIE_OP_ADD_LITERAL |=>
		status.digit_carry_flag == ({1'b0, $past(accumulator[3:0])} + {1'b0, $past(instr.literal[3:0])} > 5'h0F))
		else $error("digit carry wrong");
	chk_and_lit: assert property (tk && op == MIE_OP_AND_LITERAL |=>
		accumulator == ($past(accumulator) & $past(instr.literal[7:0]))
		&& $stable(status.carry_flag) && $stable(status.digit_carry_flag)) else $error("and literal wrong");
	chk_bit_set: assert property (tk && op == MIE_OP_BIT_SET |=> file_wr_en && $stable(status)
		&& file_wr_data == ($past(file_rd_data) | (8'h01 << $past(instr.bit_sel))))
		else $error("bit set wrong");
	chk_rel_branch: assert property (tk && op == MIE_OP_RELATIVE_BRANCH |=> pc_load
		&& pc_target == $past(pc_current) + 15'h0001 + {{6{$past(instr.literal[8])}}, $past(instr.literal[8:0])})
		else $error("relative branch target wrong");
	chk_call_push: assert property (tk && op == MIE_OP_CALL |=> stack_push && pc_load
		&& stack_top == $past(pc_current) + 15'h0001
		&& pc_target == {$past(pc_high_latch[6:3]), $past(instr.literal)}) else $error("call wrong");
	chk_wdt_clear: assert property (tk && op == MIE_OP_WATCHDOG_CLEAR |=> watchdog_clear
		&& status.timeout_flag && status.powerdown_flag) else $error("watchdog clear wrong");
	chk_absolute_branch_flush: assert property (tk && op == MIE_OP_ABSOLUTE_BRANCH |=>
		!instr_ready [*7] ##1 instr_ready) else $error("branch slot count wrong");

	cover property (tk && op == MIE_OP_CALL);
	cover property (tk && op == MIE_OP_BIT_TEST_SKIP_SET);
	cover property (tk && instr.indirect);
endmodule : mie_execute_checker

bind mie_execute mie_execute_checker u_chk (
	.core_clk(core_clk), .reset_n(reset_n), .instr_valid(instr_valid), .instr(instr),
	.instr_ready(instr_ready), .file_rd_data(file_rd_data), .pc_current(pc_current),
	.pc_high_latch(pc_high_latch), .file_wr_en(file_wr_en), .file_wr_data(file_wr_data),
	.pc_load(pc_load), .pc_target(pc_target), .stack_push(stack_push), .stack_top(stack_top),
	.watchdog_clear(watchdog_clear), .accumulator(accumulator), .status(status),
	.osc_phase(osc_phase)
);
`default_nettype wire

/* dv/mie_execute_tb_top.sv */
// Self-checking testbench for the instruction execute block
`timescale 1ns/10ps
`default_nettype none
module mie_execute_tb_top
	import mie_pkg::*;
;
	// Inputs {d,bit,indirect,literal,file}, results {w,wen_flags,wdata,target,slots}
	typedef struct {
		mie_op_type  op;
		logic [23:0] i;
		logic [39:0] e;
	} mie_row_type;

	logic           core_clk = 1'b0;
	logic           reset_n;
	logic           instr_valid;
	mie_instr_type  instr;
	logic           instr_ready;
	logic [6:0]     file_rd_addr;
	logic [7:0]     file_rd_data;
	logic           file_wr_en;
	logic [6:0]     file_wr_addr;
	logic [7:0]     file_wr_data;
	logic [15:0]    ptrs [2];
	logic [14:0]    pc_current;
	logic [6:0]     pc_high_latch;
	logic           pc_load;
	logic [14:0]    pc_target;
	logic           stack_push;
	logic [14:0]    stack_top;
	logic           watchdog_clear;
	logic [7:0]     accumulator;
	mie_status_type status;
	logic [1:0]     osc_phase;
	logic           cycle_strobe;
	int             fail_count = 0;
	int             check_count = 0;
	int             i;
	mie_row_type    r;
	logic [10:0]    pl [3] = '{11'h020, 11'h01F, 11'h001};
	logic [15:0]    pe [3] = '{16'hFFE0, 16'hFFFF, 16'h0000};
	mie_row_type    rows [32] = '{
		'{MIE_OP_ADD_LITERAL, 24'h0_08F_00, 40'h8F_0_00_0000_1},
		'{MIE_OP_ADD_LITERAL, 24'h0_071_00, 40'h00_7_00_0000_1},
		'{MIE_OP_ADD_REGISTER_WITH_CARRY, 24'h0_000_07, 40'h08_0_00_0000_1},
		'{MIE_OP_ADD_REGISTER, 24'h8_000_F8, 40'h08_F_00_0000_1},
		'{MIE_OP_AND_LITERAL, 24'h0_00C_00, 40'h08_3_00_0000_1},
		'{MIE_OP_OR_LITERAL, 24'h0_031_00, 40'h39_3_00_0000_1},
		'{MIE_OP_ARITH_SHIFT_RIGHT, 24'h8_000_81, 40'h39_B_C0_0000_1},
		'{MIE_OP_ARITH_SHIFT_RIGHT, 24'h0_000_01, 40'h00_7_00_0000_1},
		'{MIE_OP_BIT_CLEAR, 24'h7_000_FF, 40'h00_F_7F_0000_1},
		'{MIE_OP_BIT_SET, 24'h0_000_00, 40'h00_F_01_0000_1},
		'{MIE_OP_ADD_LITERAL, 24'h0_005_00, 40'h05_0_00_0000_1},
		'{MIE_OP_CLEAR_REGISTER, 24'h8_000_55, 40'h05_C_00_0000_1},
		'{MIE_OP_DECREMENT_REGISTER, 24'h0_000_10, 40'h0F_0_00_0000_1},
		'{MIE_OP_DECREMENT_SKIP_ZERO, 24'h8_000_01, 40'h0F_8_00_0000_2},
		'{MIE_OP_DECREMENT_SKIP_ZERO, 24'h0_000_03, 40'h02_0_00_0000_1},
		'{MIE_OP_INCREMENT_SKIP_ZERO, 24'h8_000_FF, 40'h02_8_00_0000_2},
		'{MIE_OP_INCREMENT_SKIP_ZERO, 24'h0_000_41, 40'h42_0_00_0000_1},
		'{MIE_OP_BIT_TEST_SKIP_CLEAR, 24'h3_000_08, 40'h42_0_00_0000_1},
		'{MIE_OP_BIT_TEST_SKIP_CLEAR, 24'h3_000_F7, 40'h42_0_00_0000_2},
		'{MIE_OP_BIT_TEST_SKIP_SET, 24'h6_000_40, 40'h42_0_00_0000_2},
		'{MIE_OP_BIT_TEST_SKIP_SET, 24'h6_000_BF, 40'h42_0_00_0000_1},
		'{MIE_OP_RELATIVE_BRANCH, 24'h0_100_00, 40'h42_0_00_0001_2},
		'{MIE_OP_RELATIVE_BRANCH, 24'h0_0FF_00, 40'h42_0_00_0200_2},
		'{MIE_OP_BRANCH_BY_ACCUMULATOR, 24'h0_000_00, 40'h42_0_00_0143_2},
		'{MIE_OP_CALL, 24'h0_7FF_00, 40'h42_0_00_2FFF_2},
		'{MIE_OP_CALL_BY_ACCUMULATOR, 24'h0_000_00, 40'h42_0_00_2A42_2},
		'{MIE_OP_ABSOLUTE_BRANCH, 24'h0_123_00, 40'h42_0_00_2923_2},
		'{MIE_OP_CLEAR_ACCUMULATOR, 24'h0_000_00, 40'h00_4_00_0000_1},
		'{MIE_OP_WATCHDOG_CLEAR, 24'h0_000_00, 40'h00_4_00_0000_1},
		'{MIE_OP_COMPLEMENT_REGISTER, 24'h8_000_F0, 40'h00_8_0F_0000_1},
		'{MIE_OP_AND_REGISTER, 24'h0_000_5A, 40'h00_4_00_0000_1},
		'{MIE_OP_NO_OPERATION, 24'h0_000_00, 40'h00_4_00_0000_1}
	};

	mie_execute uut (
		.core_clk(core_clk), .reset_n(reset_n), .instr_valid(instr_valid), .instr(instr),
		.instr_ready(instr_ready), .file_rd_addr(file_rd_addr), .file_rd_data(file_rd_data),
		.file_wr_en(file_wr_en), .file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data),
		.indirect_pointer_pair(ptrs), .pc_current(pc_current), .pc_high_latch(pc_high_latch),
		.pc_load(pc_load), .pc_target(pc_target), .stack_push(stack_push),
		.stack_top(stack_top), .watchdog_clear(watchdog_clear), .accumulator(accumulator),
		.status(status), .osc_phase(osc_phase), .cycle_strobe(cycle_strobe)
	);

	always #4 core_clk = ~core_clk;

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : summarize

	// Issue one instruction, check its results and the slots it holds
	task automatic exec(input mie_row_type x);
		int   n;
		logic cl;
		cl = x.op == MIE_OP_CALL || x.op == MIE_OP_CALL_BY_ACCUMULATOR;
		@(posedge core_clk);
		instr <= '{op: x.op, dest_file: x.i[23], file_addr: 7'h2C, bit_sel: x.i[22:20],
			ptr_sel: x.i[20], literal: x.i[18:8], indirect: x.i[19]};
		file_rd_data <= x.i[7:0];
		instr_valid <= 1'b1;
		n = 0;
		#1;
		while (instr_ready !== 1'b1 && n < 20) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		chk({cycle_strobe, file_rd_addr}, {1'b1, 7'h2C});
		@(posedge core_clk);
		instr_valid <= 1'b0;
		#1;
		chk(accumulator, x.e[39:32]);
		chk(status, {2'b11, x.e[30:28]});
		chk(file_wr_en, x.e[31]);
		if (x.e[31]) chk({file_wr_addr, file_wr_data}, {7'h2C, x.e[27:20]});
		chk(pc_load, x.e[18:4] != 15'h0000);
		if (x.e[18:4] != 15'h0000) chk(pc_target, x.e[18:4]);
		chk(stack_push, cl);
		if (cl) chk(stack_top, 15'h0101);
		chk(watchdog_clear, x.op == MIE_OP_WATCHDOG_CLEAR);
		n = 0;
		do begin
			@(posedge core_clk);
			#1;
			n++;
		end while (instr_ready !== 1'b1 && n < 20);
		chk(n, 4 * x.e[3:0] - 1);
	endtask : exec

	task automatic rst_chk();
		chk(accumulator, 8'h00);
		chk(status, 5'h18);
		chk(instr_ready, 1'b0);
		chk(ptrs[1], 16'h0000);
		chk({osc_phase, cycle_strobe}, 3'h0);
	endtask : rst_chk

	initial begin
		reset_n = 1'b0;
		instr_valid = 1'b0;
		instr = '0;
		file_rd_data = 8'h00;
		pc_current = 15'h0100;
		pc_high_latch = 7'h2A;
		repeat (19) @(posedge core_clk);
		#1;
		rst_chk();
		@(posedge core_clk);
		reset_n <= 1'b1;
		for (i = 0; i < 32; i++) exec(rows[i]);
		$display("instruction table done");
		// Pointer wraps both ways; indirect cost follows its top bit
		for (i = 0; i < 3; i++) begin
			r = '{MIE_OP_ADD_LITERAL_TO_POINTER, {5'h02, pl[i], 8'h00}, 40'h00_4_00_0000_1};
			exec(r);
			chk(ptrs[1], pe[i]);
			chk(ptrs[0], 16'h0000);
			r = '{MIE_OP_BIT_SET, 24'h1_800_00, {12'h00C, 8'h02, 16'h0000, 2'h0, pe[i][15], ~pe[i][15]}};
			exec(r);
		end
		$display("pointer test done");
		@(posedge core_clk);
		reset_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		#1;
		rst_chk();
		@(posedge core_clk);
		reset_n <= 1'b1;
		exec(rows[0]);
		$display("mid-run reset test done");
		summarize();
	end

	// Whole run needs about four hundred cycles
	initial begin
		#50000;
		fail_count++;
		summarize();
	end
endmodule : mie_execute_tb_top
`default_nettype wire
